// [verilog/sim_pkg.sv]
// How it works
// - Transmit request when stop bit leaves shifter
// - Receive request when character enters receive buffer
// - Overrun when eighth bit beats buffer read
// - No receive request for an overrunning character
// - Framing error when stop bit is low
// - Error summary is OR of three errors
// - Prescaler passes clock or divides by 2^n
// - Two-bit select picks the divider count source
// - Handshake select bit ignored, no flow pins
// - Readable flag: transmit shifter empty
// - Readable flag: transmit buffer empty
// - Error low level only when output enabled
// - Parity fail drives transmit line low
// - Buffer read clears parity error, releases line
// - Direct send: true data, LSB first, even
// - Direct receive: true data, bit zero first
// - Inverse send: complemented, MSB first, odd
// - Inverse receive: complemented, stored from bit seven
// - Inverse receive checks odd parity
package sim_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] OFS_TX_BUF  = 4'h0;
  localparam logic [3:0] OFS_RX_BUF  = 4'h1;
  localparam logic [3:0] OFS_BAUD    = 4'h2;
  localparam logic [3:0] OFS_MODE    = 4'h3;
  localparam logic [3:0] OFS_CTRL0   = 4'h4;
  localparam logic [3:0] OFS_CTRL1   = 4'h5;
  localparam logic [3:0] OFS_SPEC1   = 4'h6;
  localparam logic [3:0] OFS_SPEC2   = 4'h7;
  localparam logic [3:0] OFS_SPEC3   = 4'h8;
  localparam logic [3:0] OFS_SPEC4   = 4'h9;
  localparam logic [3:0] OFS_PRESC   = 4'hA;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int MODE_PARITY_POL  = 5;
  localparam int CTRL0_CLK_LO     = 0;
  localparam int CTRL0_CTS_RTS    = 2;
  localparam int CTRL0_TX_EMPTY   = 3;
  localparam int CTRL0_OPEN_DRAIN = 5;
  localparam int CTRL0_MSB_FIRST  = 7;
  localparam int CTRL1_TX_EN      = 0;
  localparam int CTRL1_TX_BUF_MT  = 1;
  localparam int CTRL1_RX_EN      = 2;
  localparam int CTRL1_RX_DONE    = 3;
  localparam int CTRL1_IRQ_SRC    = 4;
  localparam int CTRL1_INVERT     = 6;
  localparam int CTRL1_PER_OUT_EN = 7;
  localparam int RXB_OVERRUN      = 12;
  localparam int RXB_FRAMING      = 13;
  localparam int RXB_PARITY       = 14;
  localparam int RXB_SUMMARY      = 15;

  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic [7:0] RST_REG8     = 8'h00;
  localparam logic [3:0] TICK_LAST    = 4'hF;
  localparam logic [3:0] TICK_MID     = 4'h7;
  localparam logic [2:0] DATA_LAST    = 3'h7;
  localparam logic [3:0] FRAME_LAST   = 4'hA;
  localparam logic [2:0] F8_LAST      = 3'h7;
  localparam logic [1:0] SRC_F1       = 2'h0;
  localparam logic [1:0] SRC_F8       = 2'h1;

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} sim_rx_e;

endpackage

// [verilog/sim_bclk_if.sv]
`timescale 1ns/1ps
// Bit clock configuration and oversampling tick
interface sim_bclk_if;
  logic [1:0] src_sel;
  logic [3:0] pre_div;
  logic [7:0] divisor;
  logic       tick;
  modport gen  (input src_sel, input pre_div, input divisor, output tick);
  modport core (output src_sel, output pre_div, output divisor, input tick);
endinterface

// [verilog/sim_baud_gen.sv]
`timescale 1ns/1ps
// ****************************************
// Bit clock generator
// ****************************************
module sim_baud_gen (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Configuration and tick
  sim_bclk_if.gen  bclk
);
  logic [14:0] free_cnt_r;
  logic [14:0] pre_mask;
  logic        src_tick;
  logic [7:0]  div_cnt_r;
  logic        tick_r;

  // Free counter feeds both f8 and the 2^n prescaler
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      free_cnt_r <= 15'h0000;
    end else begin
      free_cnt_r <= free_cnt_r + 15'h0001;
    end
  end

  // n=0 gives an all-zero mask, i.e. undivided
  always_comb begin
    pre_mask = 15'((16'h0001 << bclk.pre_div) - 16'h0001);
    unique case (bclk.src_sel)
      sim_pkg::SRC_F1: src_tick = 1'b1;
      sim_pkg::SRC_F8: src_tick = (free_cnt_r[2:0] == sim_pkg::F8_LAST);
      default:         src_tick = ((free_cnt_r & pre_mask) == pre_mask);
    endcase
  end

  // Divide source by divisor+1; the x16 is done in the core
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      div_cnt_r <= 8'h00;
      tick_r    <= 1'b0;
    end else begin
      tick_r <= 1'b0;
      if (src_tick) begin
        if (div_cnt_r == 8'h00) begin
          div_cnt_r <= bclk.divisor;
          tick_r    <= 1'b1;
        end else begin
          div_cnt_r <= div_cnt_r - 8'h01;
        end
      end
    end
  end

  assign bclk.tick = tick_r;

endmodule

// [verilog/sim_uart.sv]
`timescale 1ns/1ps
// ****************************************
// Smart-card serial channel
// ****************************************
module sim_uart (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Serial line
  input  wire logic        rx_line_i,
  output logic             tx_line_o,
  output logic             tx_oe_o,
  // Request pulses
  output logic             tx_irq_o,
  output logic             rx_irq_o
);
  sim_bclk_if bclk ();

  // Software registers
  logic [7:0]  tx_buf_r;
  logic [7:0]  baud_r;
  logic [7:0]  mode_r;
  logic [7:0]  ctrl0_r;
  logic [7:0]  ctrl1_r;
  logic [7:0]  spec_r [4];
  logic [3:0]  presc_r;
  logic [15:0] rdata_r;
  // Transmit side
  logic        tb_full_r;
  logic        tx_busy_r;
  logic [10:0] tx_frame_r;
  logic [3:0]  tx_tick_r;
  logic [3:0]  tx_bit_r;
  logic        tx_line_r;
  logic        tx_oe_r;
  logic        tx_irq_r;
  logic [7:0]  tx_data;
  logic [7:0]  tx_order;
  logic        tx_par;
  logic        tx_start;
  logic        tx_done;
  // Receive side
  logic        rx_s1_r;
  logic        rx_s2_r;
  logic        rx_prev_r;
  sim_pkg::sim_rx_e rx_st_r;
  logic [3:0]  rx_tick_r;
  logic [2:0]  rx_idx_r;
  logic [7:0]  rx_sh_r;
  logic        rx_acc_r;
  logic        rx_ovr_chr_r;
  logic [7:0]  rb_data_r;
  logic        rx_done_r;
  logic        ovr_r;
  logic        frame_err_r;
  logic        per_r;
  logic        rx_irq_r;
  logic        per_drive_r;
  logic [3:0]  per_cnt_r;
  logic        rx_bit;
  logic        rx_val;
  logic        rx_samp;
  logic        rx_eighth;
  logic        rx_xfer;
  logic        rx_perr;
  logic        per_set;
  // Decoded accesses
  logic        wr_tb;
  logic        wr_c1;
  logic        rd_rb;
  logic        tick;

  assign tick  = bclk.tick;
  assign wr_tb = reg_wr && (reg_addr == sim_pkg::OFS_TX_BUF);
  assign wr_c1 = reg_wr && (reg_addr == sim_pkg::OFS_CTRL1);
  assign rd_rb = reg_rd && (reg_addr == sim_pkg::OFS_RX_BUF);

  // ****************************************
  // Bit clock
  // ****************************************
  assign bclk.src_sel = ctrl0_r[sim_pkg::CTRL0_CLK_LO +: 2];
  assign bclk.pre_div = presc_r;
  assign bclk.divisor = baud_r;

  sim_baud_gen u_baud (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .bclk    (bclk.gen)
  );

  // ****************************************
  // Register writes
  // ****************************************
  // Handshake select is stored only; no flow-control pin exists
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_buf_r <= sim_pkg::RST_REG8;
      baud_r   <= sim_pkg::RST_REG8;
      mode_r   <= sim_pkg::RST_REG8;
      ctrl0_r  <= sim_pkg::RST_REG8;
      ctrl1_r  <= sim_pkg::RST_REG8;
      presc_r  <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        spec_r[i] <= sim_pkg::RST_REG8;
      end
    end else if (reg_wr) begin
      unique case (reg_addr)
        sim_pkg::OFS_TX_BUF: tx_buf_r <= reg_wdata[7:0];
        sim_pkg::OFS_BAUD:   baud_r   <= reg_wdata[7:0];
        sim_pkg::OFS_MODE:   mode_r   <= reg_wdata[7:0];
        sim_pkg::OFS_CTRL0:  ctrl0_r  <= reg_wdata[7:0];
        sim_pkg::OFS_CTRL1:  ctrl1_r  <= reg_wdata[7:0];
        sim_pkg::OFS_SPEC1:  spec_r[0] <= reg_wdata[7:0];
        sim_pkg::OFS_SPEC2:  spec_r[1] <= reg_wdata[7:0];
        sim_pkg::OFS_SPEC3:  spec_r[2] <= reg_wdata[7:0];
        sim_pkg::OFS_SPEC4:  spec_r[3] <= reg_wdata[7:0];
        sim_pkg::OFS_PRESC:  presc_r  <= reg_wdata[3:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  // Data valid only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata_r <= 16'h0000;
    end else if (!reg_rd) begin
      rdata_r <= 16'h0000;
    end else begin
      unique case (reg_addr)
        sim_pkg::OFS_RX_BUF: rdata_r <= {(ovr_r | frame_err_r | per_r), per_r, frame_err_r, ovr_r,
                                         4'h0, rb_data_r};
        sim_pkg::OFS_BAUD:   rdata_r <= {8'h00, baud_r};
        sim_pkg::OFS_MODE:   rdata_r <= {8'h00, mode_r};
        sim_pkg::OFS_CTRL0:  rdata_r <= {8'h00, ctrl0_r[7:4], ~tx_busy_r,
                                         ctrl0_r[2:0]};
        sim_pkg::OFS_CTRL1:  rdata_r <= {8'h00, ctrl1_r[7:4], rx_done_r, ctrl1_r[2],
                                         ~tb_full_r, ctrl1_r[0]};
        sim_pkg::OFS_SPEC1:  rdata_r <= {8'h00, spec_r[0]};
        sim_pkg::OFS_SPEC2:  rdata_r <= {8'h00, spec_r[1]};
        sim_pkg::OFS_SPEC3:  rdata_r <= {8'h00, spec_r[2]};
        sim_pkg::OFS_SPEC4:  rdata_r <= {8'h00, spec_r[3]};
        sim_pkg::OFS_PRESC:  rdata_r <= {12'h000, presc_r};
        default:             rdata_r <= 16'h0000;
      endcase
    end
  end

  assign reg_rdata = rdata_r;

  // ****************************************
  // Transmitter
  // ****************************************
  // Format: optional complement, optional bit reversal, parity on the wire bits
  assign tx_data = ctrl1_r[sim_pkg::CTRL1_INVERT] ? ~tx_buf_r : tx_buf_r;
  for (genvar g = 0; g < 8; g++) begin : g_rev
    assign tx_order[g] = ctrl0_r[sim_pkg::CTRL0_MSB_FIRST] ? tx_data[7 - g]
                                                            : tx_data[g];
  end
  assign tx_par   = mode_r[sim_pkg::MODE_PARITY_POL] ? ^tx_data : ~^tx_data;
  assign tx_start = ctrl1_r[sim_pkg::CTRL1_TX_EN] && tb_full_r && !tx_busy_r;
  assign tx_done  = tx_busy_r && tick && (tx_tick_r == sim_pkg::TICK_LAST)
                    && (tx_bit_r == sim_pkg::FRAME_LAST);

  // Buffer full; a write in the load cycle refills it, nothing is lost
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tb_full_r <= 1'b0;
    end else begin
      tb_full_r <= (tb_full_r && !tx_start) || wr_tb;
    end
  end

  // Shifter: start, 8 data, parity, stop, 16 ticks each
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_busy_r  <= 1'b0;
      tx_frame_r <= 11'h7FF;
      tx_tick_r  <= 4'h0;
      tx_bit_r   <= 4'h0;
    end else if (tx_start) begin
      tx_busy_r  <= 1'b1;
      tx_frame_r <= {1'b1, tx_par, tx_order, 1'b0};
      tx_tick_r  <= 4'h0;
      tx_bit_r   <= 4'h0;
    end else if (tx_busy_r && tick) begin
      tx_tick_r <= tx_tick_r + 4'h1;
      if (tx_tick_r == sim_pkg::TICK_LAST) begin
        tx_frame_r <= {1'b1, tx_frame_r[10:1]};
        tx_bit_r   <= tx_bit_r + 4'h1;
        if (tx_bit_r == sim_pkg::FRAME_LAST) begin
          tx_busy_r <= 1'b0;
        end
      end
    end
  end

  // Request on buffer load, or on stop-bit end if software chose that
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_irq_r <= 1'b0;
    end else begin
      tx_irq_r <= ctrl1_r[sim_pkg::CTRL1_IRQ_SRC] ? tx_done : tx_start;
    end
  end

  // Line driver; error low overrides data, open drain only pulls low
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_line_r <= 1'b1;
      tx_oe_r   <= 1'b0;
    end else begin
      tx_line_r <= !per_drive_r && (!tx_busy_r || tx_frame_r[0]);
      tx_oe_r   <= ctrl0_r[sim_pkg::CTRL0_OPEN_DRAIN]
                   ? (per_drive_r || (tx_busy_r && !tx_frame_r[0])) : 1'b1;
    end
  end

  assign tx_line_o = tx_line_r;
  assign tx_oe_o   = tx_oe_r;
  assign tx_irq_o  = tx_irq_r;

  // ****************************************
  // Receiver
  // ****************************************
  // Two-flop synchroniser; only the second stage is looked at
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rx_s1_r   <= 1'b1;
      rx_s2_r   <= 1'b1;
      rx_prev_r <= 1'b1;
    end else begin
      rx_s1_r   <= rx_line_i;
      rx_s2_r   <= rx_s1_r;
      rx_prev_r <= rx_s2_r;
    end
  end

  assign rx_bit    = rx_s2_r;
  assign rx_val    = rx_bit ^ ctrl1_r[sim_pkg::CTRL1_INVERT];
  assign rx_samp   = tick && (rx_tick_r == sim_pkg::TICK_LAST);
  assign rx_eighth = (rx_st_r == sim_pkg::RX_DATA) && rx_samp
                     && (rx_idx_r == sim_pkg::DATA_LAST);
  assign rx_xfer   = (rx_st_r == sim_pkg::RX_STOP) && rx_samp;
  // Parity over wire bits; polarity bit picks even or odd
  assign rx_perr   = mode_r[sim_pkg::MODE_PARITY_POL] ? rx_acc_r : !rx_acc_r;
  assign per_set   = rx_xfer && rx_perr;

  // Frame sequencer, sampling mid-bit at 16x oversampling
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rx_st_r   <= sim_pkg::RX_IDLE;
      rx_tick_r <= 4'h0;
      rx_idx_r  <= 3'h0;
      rx_sh_r   <= 8'h00;
      rx_acc_r  <= 1'b0;
    end else begin
      if (tick) begin
        rx_tick_r <= rx_tick_r + 4'h1;
      end
      unique case (rx_st_r)
        sim_pkg::RX_IDLE: begin
          if (ctrl1_r[sim_pkg::CTRL1_RX_EN] && rx_prev_r && !rx_bit) begin
            rx_st_r   <= sim_pkg::RX_START;
            rx_tick_r <= 4'h0;
          end
        end
        sim_pkg::RX_START: begin
          // A short glitch is rejected at the half-bit check
          if (tick && (rx_tick_r == sim_pkg::TICK_MID)) begin
            rx_st_r   <= rx_bit ? sim_pkg::RX_IDLE : sim_pkg::RX_DATA;
            rx_tick_r <= 4'h0;
            rx_idx_r  <= 3'h0;
            rx_acc_r  <= 1'b0;
          end
        end
        sim_pkg::RX_DATA: begin
          if (rx_samp) begin
            rx_acc_r <= rx_acc_r ^ rx_bit;
            rx_idx_r <= rx_idx_r + 3'h1;
            rx_sh_r  <= ctrl0_r[sim_pkg::CTRL0_MSB_FIRST] ? {rx_sh_r[6:0], rx_val}
                                                          : {rx_val, rx_sh_r[7:1]};
            if (rx_idx_r == sim_pkg::DATA_LAST) begin
              rx_st_r <= sim_pkg::RX_PAR;
            end
          end
        end
        sim_pkg::RX_PAR: begin
          if (rx_samp) begin
            rx_acc_r <= rx_acc_r ^ rx_bit;
            rx_st_r  <= sim_pkg::RX_STOP;
          end
        end
        sim_pkg::RX_STOP: begin
          if (rx_samp) begin
            rx_st_r <= sim_pkg::RX_IDLE;
          end
        end
        default: rx_st_r <= sim_pkg::RX_IDLE;
      endcase
    end
  end

  // Buffer and completion flag; hardware set wins over read clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rb_data_r <= 8'h00;
      rx_done_r <= 1'b0;
      rx_irq_r  <= 1'b0;
    end else begin
      rx_irq_r <= rx_xfer && !rx_ovr_chr_r;
      if (rx_xfer) begin
        rb_data_r <= rx_sh_r;
        rx_done_r <= 1'b1;
      end else if (rd_rb) begin
        rx_done_r <= 1'b0;
      end
    end
  end

  // Overrun at eighth bit with buffer unread; errors clear when receive is off
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ovr_r        <= 1'b0;
      frame_err_r  <= 1'b0;
      rx_ovr_chr_r <= 1'b0;
    end else begin
      if (rx_eighth) begin
        rx_ovr_chr_r <= rx_done_r && !rd_rb;
      end
      if (rx_eighth && rx_done_r && !rd_rb) begin
        ovr_r <= 1'b1;
      end else if (wr_c1 && !reg_wdata[sim_pkg::CTRL1_RX_EN]) begin
        ovr_r <= 1'b0;
      end
      if (rx_xfer && !rx_bit) begin
        frame_err_r <= 1'b1;
      end else if (wr_c1 && !reg_wdata[sim_pkg::CTRL1_RX_EN]) begin
        frame_err_r <= 1'b0;
      end
    end
  end

  // Parity flag and one-bit error low; a buffer read ends both early
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      per_r       <= 1'b0;
      per_drive_r <= 1'b0;
      per_cnt_r   <= 4'h0;
    end else begin
      if (per_set) begin
        per_r <= 1'b1;
      end else if (rd_rb || (wr_c1 && !reg_wdata[sim_pkg::CTRL1_RX_EN])) begin
        per_r <= 1'b0;
      end
      if (per_set && ctrl1_r[sim_pkg::CTRL1_PER_OUT_EN]) begin
        per_drive_r <= 1'b1;
        per_cnt_r   <= 4'h0;
      end else if (per_drive_r && rd_rb) begin
        per_drive_r <= 1'b0;
      end else if (per_drive_r && tick) begin
        per_cnt_r <= per_cnt_r + 4'h1;
        if (per_cnt_r == sim_pkg::TICK_LAST) begin
          per_drive_r <= 1'b0;
        end
      end
    end
  end

  assign rx_irq_o = rx_irq_r;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_per_read;
    per_drive_r && rd_rb && !per_set;
  endsequence

  sequence s_line_back;
    !per_r && !per_drive_r ##1 tx_line_o || tx_busy_r;
  endsequence

  tx_done_irq_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tx_done && ctrl1_r[sim_pkg::CTRL1_IRQ_SRC] |=> tx_irq_o && !tx_busy_r)
    else $error("transmit request missing after stop bit");

  rx_xfer_irq_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rx_xfer && !rx_ovr_chr_r |=> rx_irq_o && rx_done_r && (rb_data_r == $past(rx_sh_r)))
    else $error("receive request or buffer wrong at transfer");

  ovr_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rx_eighth && rx_done_r && !rd_rb |=> ovr_r)
    else $error("overrun not flagged");

  ovr_no_irq_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rx_xfer && rx_ovr_chr_r |=> !rx_irq_o)
    else $error("request raised for overrun character");

  stop_frame_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rx_xfer && !rx_bit |=> frame_err_r)
    else $error("framing error not flagged");

  err_sum_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rd_rb |=> reg_rdata[sim_pkg::RXB_SUMMARY] == (|reg_rdata[14:12]))
    else $error("summary flag disagrees with errors");

  per_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(per_drive_r) |-> $past(ctrl1_r[sim_pkg::CTRL1_PER_OUT_EN]) && $past(per_set))
    else $error("error low without enable");

  per_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    per_set && ctrl1_r[sim_pkg::CTRL1_PER_OUT_EN] |=> ##1 !tx_line_o)
    else $error("line not pulled low on parity error");

  per_release_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_per_read |=> s_line_back)
    else $error("read did not clear parity error and release line");

  tx_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(tx_busy_r) |-> $past(ctrl1_r[sim_pkg::CTRL1_TX_EN]) && $past(tb_full_r))
    else $error("transmission started while disabled or empty");

endmodule

// [tb/sim_card.sv]
`timescale 1ns/1ps
// ********
// Card model
// ********
module sim_card (
  // Clock
  input wire logic clk_sys,
  // Open-drain pull on the shared line
  output logic     card_low
);
  initial card_low = 1'b0;
  // One frame, start bit first, 16 clocks a bit; released after
  task automatic send(input logic [10:0] f);
    for (int i = 0; i < 11; i++) begin
      card_low <= ~f[i];
      repeat (16) @(posedge clk_sys);
    end
    // Release with one edge passing, so back-to-back frames never clash
    card_low <= 1'b0;
    @(posedge clk_sys);
  endtask
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
// ********
// Bench
// ********
module tb_top;
  logic        clk_sys, rst_n, wr, rd, txl, oe, tirq, rirq, card_low, rxw, pin_tx;
  logic [3:0]  addr;
  logic [15:0] wd, rdata;
  logic [10:0] f;
  logic [7:0]  d;
  int          n_fail, num_checks, ntx, nrx, cyc, k, t, s;
  int          pre_n [3] = '{0, 2, 0};
  int          bit_len [3] = '{128, 64, 16};

  // Pull-up line: either party may pull it low
  assign rxw = ~((oe & ~txl) | card_low);

  sim_uart dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .rx_line_i(rxw), .tx_line_o(txl),
    .tx_oe_o(oe), .tx_irq_o(tirq), .rx_irq_o(rirq));
  sim_card card (.clk_sys(clk_sys), .card_low(card_low));

  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Pulse counts and run ceiling
  always @(posedge clk_sys) begin
    // Pin level at end of transmit, as a handler would read it
    if (tirq === 1'b1) begin
      ntx++;
      pin_tx = rxw;
    end
    if (rirq === 1'b1) nrx++;
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Gap cycle after each write, so strobes never toggle twice at once
  task automatic wr_r(input logic [3:0] a, input logic [15:0] v);
    addr <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m = 16'hFFFF);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    // Read data stand only in this cycle; look at them mid-cycle
    @(negedge clk_sys);
    chk(rdata & m, e);
    @(posedge clk_sys);
  endtask

  // Wire frame: start, eight data in wire order, parity, stop
  function automatic logic [10:0] fr(input logic [7:0] v, input logic inv, bad, stp);
    logic [7:0] w;
    for (int i = 0; i < 8; i++) w[i] = inv ? ~v[7 - i] : v[i];
    return {stp, (inv ? ~^w : ^w) ^ bad, w, 1'b0};
  endfunction

  // Mid-bit samples of one frame on the transmit output
  task automatic grab(output logic [10:0] g);
    for (int i = 0; txl !== 1'b0 && i < 3000; i++) @(posedge clk_sys);
    repeat (8) @(posedge clk_sys);
    for (int i = 0; i < 11; i++) begin
      g[i] = txl;
      repeat (16) @(posedge clk_sys);
    end
  endtask

  initial begin
    {rst_n, wr, rd, addr, wd} = '0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rdc(4'hB, 16'h0000);
    rdc(sim_pkg::OFS_SPEC1, 16'h0000);
    // Own characters loop back through the shared line
    for (k = 0; k < 2; k++) begin
      d = k ? 8'h3C : 8'hA5;
      wr_r(sim_pkg::OFS_MODE, k ? 16'h0000 : 16'h0020);
      wr_r(sim_pkg::OFS_CTRL0, k ? 16'h00A0 : 16'h0024);
      wr_r(sim_pkg::OFS_CTRL1, k ? 16'h00D5 : 16'h0095);
      if (k == 0) begin
        rdc(sim_pkg::OFS_CTRL0, 16'h002C);
        rdc(sim_pkg::OFS_CTRL1, 16'h0097);
      end
      t = ntx;
      s = nrx;
      wr_r(sim_pkg::OFS_TX_BUF, {8'h00, d});
      grab(f);
      chk({5'h00, f}, {5'h00, fr(d, k[0], 1'b0, 1'b1)});
      chk(16'(ntx - t), 16'h0001);
      chk({15'h0000, pin_tx}, 16'h0001);
      chk(16'(nrx - s), 16'h0001);
      rdc(sim_pkg::OFS_RX_BUF, {8'h00, d});
    end
    // Parity fault from the card, error output off then on
    wr_r(sim_pkg::OFS_MODE, 16'h0020);
    wr_r(sim_pkg::OFS_CTRL0, 16'h0020);
    for (k = 0; k < 2; k++) begin
      wr_r(sim_pkg::OFS_CTRL1, k ? 16'h0095 : 16'h0015);
      card.send(fr(8'h5A, 1'b0, 1'b1, 1'b1));
      chk({15'h0000, txl}, {15'h0000, ~k[0]});
      rdc(sim_pkg::OFS_RX_BUF, 16'hC05A);
      repeat (2) @(posedge clk_sys);
      chk({15'h0000, txl}, 16'h0001);
      wr_r(sim_pkg::OFS_CTRL1, 16'h0011);
      repeat (300) @(posedge clk_sys);
    end
    // Two characters with no read between
    wr_r(sim_pkg::OFS_CTRL1, 16'h0015);
    s = nrx;
    card.send(fr(8'h11, 1'b0, 1'b0, 1'b1));
    card.send(fr(8'h22, 1'b0, 1'b0, 1'b1));
    repeat (20) @(posedge clk_sys);
    chk(16'(nrx - s), 16'h0001);
    rdc(sim_pkg::OFS_RX_BUF, 16'h9000, 16'hF000);
    // Stop bit held low
    wr_r(sim_pkg::OFS_CTRL1, 16'h0011);
    wr_r(sim_pkg::OFS_CTRL1, 16'h0015);
    card.send(fr(8'h33, 1'b0, 1'b0, 1'b0));
    repeat (20) @(posedge clk_sys);
    rdc(sim_pkg::OFS_RX_BUF, 16'hA033);
    // Loaded buffer waits for transmit enable
    wr_r(sim_pkg::OFS_CTRL1, 16'h0010);
    wr_r(sim_pkg::OFS_TX_BUF, 16'h00FF);
    repeat (40) @(posedge clk_sys);
    chk({15'h0000, txl}, 16'h0001);
    // Low parity bit length per count source and prescaler
    for (k = 0; k < 3; k++) begin
      wr_r(sim_pkg::OFS_CTRL0, 16'(33 + k));
      wr_r(sim_pkg::OFS_PRESC, 16'(pre_n[k]));
      if (k == 0) wr_r(sim_pkg::OFS_CTRL1, 16'h0011);
      else wr_r(sim_pkg::OFS_TX_BUF, 16'h00FF);
      // Start bit is cut by tick phase; the low parity bit of FF is whole
      for (t = 0; txl !== 1'b0 && t < 300; t++) @(posedge clk_sys);
      for (t = 0; txl !== 1'b1 && t < 300; t++) @(posedge clk_sys);
      for (t = 0; txl !== 1'b0 && t < 1100; t++) @(posedge clk_sys);
      for (t = 0; txl === 1'b0 && t < 300; t++) @(posedge clk_sys);
      chk(16'(t), 16'(bit_len[k]));
      repeat (11 * bit_len[k]) @(posedge clk_sys);
    end
    end_sim();
  end
endmodule
